// ===== src/diag_regs_cfg.svh
`ifndef DIAG_REGS_CFG_SVH
`define DIAG_REGS_CFG_SVH

// register byte offsets, one aligned word each
`define ADDR_W 8
`define REG_DIAG_LO 8'h00
`define REG_DIAG_HI 8'h04
`define REG_IVEC_LO 8'h08
`define REG_IVEC_HI 8'h0C
`define REG_HALT_LO 8'h10
`define REG_HALT_HI 8'h14
`define REG_PERR_LO 8'h18
`define REG_PERR_HI 8'h1C
`define REG_CAP_LO 8'h20
`define REG_CAP_HI 8'h24
`define REG_IOCTL_LO 8'h28
`define REG_IOCTL_HI 8'h2C
// diagnostic datapath windows, selected by haddr[7:5], word index in haddr[4:2]
`define WIN_EVEN_SEL 3'h2
`define WIN_ODD_SEL 3'h3

// field positions inside each slice word
`define DIAG_MODE_BIT 0
`define DIAG_MERGE_BIT 1
`define PERR_DATA_BIT 0
`define PERR_ADDR_BIT 1
`define FB_RST_BIT 7
`define VEC_W 16

// reset values and sizes
`define DIAG_RESET 16'h0000
`define DIAG_LINE_WORDS 4
`define IVEC_QUEUE_DEPTH 8
`define HSIZE_WORD 3'h2

`endif

// ===== src/diag_regs_pkg.sv
package diag_regs_pkg;
  typedef logic [15:0] vec_t;
  typedef struct packed {
    logic [13:0] scratch;
    logic merge;
    logic mode;
  } slice_cfg_t;
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} bus_phase_t;
endpackage

// ===== src/diag_vector_regs.sv
// Contract
// - two per-slice scratch fields, read and write, zero after reset
// - merge select picks read-line buffer or write buffer for diagnostic readback
// - diagnostic mode takes the slice datapath and blocks all DMA
// - other diagnostic controls act only while that slice is in diagnostic mode
// - diagnostic mode gives direct read/write of cache-line buffer words
// - even mode bit and both merge bits clear at reset
// - vector register shows queue head; each read removes one entry
// - reading an empty vector queue returns zero and changes nothing
// - vector queue empties at reset and when both remote reset bits set
// - remote halt request writes a vector that the halt register shows
// - reading the halt register consumes it and reopens the request slot
// - after consumption halt register reads zero until a new vector arrives
// - halt register clears at reset and when both remote reset bits set
// - slice address parity failure in connection phase sets its flag
// - both slices may flag the same address parity error together
// - slice data parity failure on slave write or mailbox read sets flag
// - any parity flag set drives the hardware error interrupt
// - parity flags clear by write one, remote reset bit, or reset
// - error address capture loads each address, freezes on address error
`include "diag_regs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module diag_vector_regs #(
  parameter int LINE_WORDS = `DIAG_LINE_WORDS,
  parameter int QUEUE_DEPTH = `IVEC_QUEUE_DEPTH,
  parameter int IDX_W = $clog2(LINE_WORDS)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [`ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // remote interrupt vectors
  input wire logic ivec_valid_i,
  input wire diag_regs_pkg::vec_t ivec_data_i,
  output logic ivec_ready_o,
  // remote halt request
  input wire logic halt_wr_i,
  input wire diag_regs_pkg::vec_t halt_data_i,
  output logic halt_slot_free_o,
  // remote parity checks, bit 0 even slice, bit 1 odd slice
  input wire logic conn_phase_i,
  input wire logic slave_wr_i,
  input wire logic mbox_rd_i,
  input wire logic [1:0] addr_perr_i,
  input wire logic [1:0] data_perr_i,
  input wire logic addr_valid_i,
  input wire logic [63:0] fb_addr_i,
  // buffer fills from normal traffic
  input wire logic line_fill_i,
  input wire logic wbuf_fill_i,
  input wire logic [IDX_W-1:0] fill_idx_i,
  input wire logic [63:0] fill_data_i,
  // status to datapath and system bus
  output logic [1:0] diag_mode_o,
  output logic dma_block_o,
  output logic hw_err_irq_o
);
  import diag_regs_pkg::*;

  bus_phase_t phase_reg, phase_next;
  logic [`ADDR_W-1:0] addr_reg, addr_next;
  logic hready_reg, hready_next;
  logic [31:0] rdata_reg, rdata_next;
  slice_cfg_t diag_reg [2];
  slice_cfg_t diag_next [2];
  logic [1:0] fb_rst_reg, fb_rst_next;
  vec_t halt_reg, halt_next;
  logic halt_full_reg, halt_full_next;
  logic irq_reg, irq_next;
  logic dma_blk_reg, dma_blk_next;
  logic [31:0] line_mem [2][LINE_WORDS];
  logic [31:0] line_next [2][LINE_WORDS];
  logic [31:0] wbuf_mem [2][LINE_WORDS];
  logic [31:0] wbuf_next [2][LINE_WORDS];

  logic req;
  logic [31:0] rd_word;
  logic [1:0] w1c_addr, w1c_data;
  logic [1:0] addr_flag, data_flag;
  logic [31:0] cap [2];
  logic win_hit;
  logic win_slice;
  logic [IDX_W-1:0] win_idx;
  logic fb_rst_both;

  vec_queue_if ivq();

  vec_queue #(
    .DEPTH(QUEUE_DEPTH)
  ) u_ivec_queue (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .q(ivq)
  );

  assign fb_rst_both = &fb_rst_reg;
  assign ivq.flush = fb_rst_both;
  assign ivq.push_valid = ivec_valid_i;
  assign ivq.push_data = ivec_data_i;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_slice
      // each slice checks its own copy of the address, so both may fire
      slice_err u_err (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .addr_err_i(addr_perr_i[s] && conn_phase_i),
        .data_err_i(data_perr_i[s] && (slave_wr_i || mbox_rd_i)),
        .addr_clr_i(w1c_addr[s]),
        .data_clr_i(w1c_data[s]),
        .fb_rst_i(fb_rst_reg[s]),
        .addr_valid_i(addr_valid_i),
        .addr_i(fb_addr_i[32*s +: 32]),
        .addr_flag_o(addr_flag[s]),
        .data_flag_o(data_flag[s]),
        .cap_o(cap[s])
      );
    end
  endgenerate

  // diagnostic window decode on the held data-phase address
  always_comb begin
    win_slice = (addr_reg[7:5] == `WIN_ODD_SEL);
    win_idx = addr_reg[2 +: IDX_W];
    win_hit = ((addr_reg[7:5] == `WIN_EVEN_SEL) || win_slice)
      && ({29'h0000000, addr_reg[4:2]} < LINE_WORDS)
      && (addr_reg[1:0] == 2'h0);
  end

  // read mux, evaluated during the wait state of a read
  always_comb begin
    rd_word = 32'h00000000;
    if (addr_reg == `REG_DIAG_LO) begin
      rd_word = {16'h0000, diag_reg[0]};
    end else if (addr_reg == `REG_DIAG_HI) begin
      rd_word = {16'h0000, diag_reg[1]};
    end else if (addr_reg == `REG_IVEC_LO) begin
      rd_word = {16'h0000, ivq.head};
    end else if (addr_reg == `REG_HALT_LO) begin
      rd_word = {16'h0000, halt_reg};
    end else if (addr_reg == `REG_PERR_LO) begin
      rd_word[`PERR_ADDR_BIT] = addr_flag[0];
      rd_word[`PERR_DATA_BIT] = data_flag[0];
    end else if (addr_reg == `REG_PERR_HI) begin
      rd_word[`PERR_ADDR_BIT] = addr_flag[1];
      rd_word[`PERR_DATA_BIT] = data_flag[1];
    end else if (addr_reg == `REG_CAP_LO) begin
      rd_word = cap[0];
    end else if (addr_reg == `REG_CAP_HI) begin
      rd_word = cap[1];
    end else if (addr_reg == `REG_IOCTL_LO) begin
      rd_word[`FB_RST_BIT] = fb_rst_reg[0];
    end else if (addr_reg == `REG_IOCTL_HI) begin
      rd_word[`FB_RST_BIT] = fb_rst_reg[1];
    end else if (win_hit) begin
      // outside diagnostic mode the window reads zero
      if (diag_reg[win_slice].mode) begin
        if (diag_reg[win_slice].merge) begin
          rd_word = wbuf_mem[win_slice][win_idx];
        end else begin
          rd_word = line_mem[win_slice][win_idx];
        end
      end
    end
  end

  always_comb begin
    phase_next = PH_IDLE;
    addr_next = addr_reg;
    hready_next = 1'b1;
    rdata_next = rdata_reg;
    diag_next = diag_reg;
    fb_rst_next = fb_rst_reg;
    halt_next = halt_reg;
    halt_full_next = halt_full_reg;
    line_next = line_mem;
    wbuf_next = wbuf_mem;
    ivq.pop = 1'b0;
    w1c_addr = 2'h0;
    w1c_data = 2'h0;
    req = hsel_i && htrans_i[1] && hready_i && (hsize_i == `HSIZE_WORD);

    // address phase; reads take one wait state so a write just before is seen
    if (req) begin
      addr_next = haddr_i;
      if (hwrite_i) begin
        phase_next = PH_WRITE;
      end else begin
        phase_next = PH_READ;
        hready_next = 1'b0;
      end
    end

    // write data phase
    if (phase_reg == PH_WRITE) begin
      if (addr_reg == `REG_DIAG_LO) begin
        diag_next[0] = hwdata_i[15:0];
      end else if (addr_reg == `REG_DIAG_HI) begin
        diag_next[1] = hwdata_i[15:0];
      end else if (addr_reg == `REG_PERR_LO) begin
        w1c_addr[0] = hwdata_i[`PERR_ADDR_BIT];
        w1c_data[0] = hwdata_i[`PERR_DATA_BIT];
      end else if (addr_reg == `REG_PERR_HI) begin
        w1c_addr[1] = hwdata_i[`PERR_ADDR_BIT];
        w1c_data[1] = hwdata_i[`PERR_DATA_BIT];
      end else if (addr_reg == `REG_IOCTL_LO) begin
        fb_rst_next[0] = hwdata_i[`FB_RST_BIT];
      end else if (addr_reg == `REG_IOCTL_HI) begin
        fb_rst_next[1] = hwdata_i[`FB_RST_BIT];
      end else if (win_hit && diag_reg[win_slice].mode) begin
        line_next[win_slice][win_idx] = hwdata_i;
      end
    end

    // read completes: data out and the read side effects
    if (phase_reg == PH_READ) begin
      rdata_next = rd_word;
      if (addr_reg == `REG_IVEC_LO) begin
        ivq.pop = 1'b1;
      end
      if ((addr_reg == `REG_HALT_LO) && halt_full_reg) begin
        halt_full_next = 1'b0;
        halt_next = '0;
      end
    end

    // a request is only taken while the slot is free, so it never meets a consume
    if (halt_wr_i && !halt_full_reg) begin
      halt_next = halt_data_i;
      halt_full_next = 1'b1;
    end
    if (fb_rst_both) begin
      halt_next = '0;
      halt_full_next = 1'b0;
    end

    // normal traffic cannot touch a slice that diagnostics own
    for (int i = 0; i < 2; i++) begin
      if (line_fill_i && !diag_reg[i].mode) begin
        line_next[i][fill_idx_i] = fill_data_i[32*i +: 32];
      end
      if (wbuf_fill_i && !diag_reg[i].mode) begin
        wbuf_next[i][fill_idx_i] = fill_data_i[32*i +: 32];
      end
    end

    irq_next = |{addr_flag, data_flag};
    dma_blk_next = diag_next[0].mode || diag_next[1].mode;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_reg <= PH_IDLE;
      addr_reg <= '0;
      hready_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      diag_reg[0] <= `DIAG_RESET;
      diag_reg[1] <= `DIAG_RESET;
      fb_rst_reg <= 2'h0;
      halt_reg <= '0;
      halt_full_reg <= 1'b0;
      irq_reg <= 1'b0;
      dma_blk_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      addr_reg <= addr_next;
      hready_reg <= hready_next;
      rdata_reg <= rdata_next;
      diag_reg <= diag_next;
      fb_rst_reg <= fb_rst_next;
      halt_reg <= halt_next;
      halt_full_reg <= halt_full_next;
      irq_reg <= irq_next;
      dma_blk_reg <= dma_blk_next;
    end
    // buffer storage has no reset, like the datapath rams it models
    line_mem <= line_next;
    wbuf_mem <= wbuf_next;
  end

  assign hreadyout_o = hready_reg;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_reg;
  assign ivec_ready_o = ivq.push_ready;
  assign halt_slot_free_o = !halt_full_reg;
  assign diag_mode_o = {diag_reg[1].mode, diag_reg[0].mode};
  assign dma_block_o = dma_blk_reg;
  assign hw_err_irq_o = irq_reg;
endmodule
`default_nettype wire

// ===== src/slice_err.sv
`timescale 1ns/1ps
`default_nettype none
module slice_err (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // qualified parity events and clears
  input wire logic addr_err_i,
  input wire logic data_err_i,
  input wire logic addr_clr_i,
  input wire logic data_clr_i,
  input wire logic fb_rst_i,
  // address capture
  input wire logic addr_valid_i,
  input wire logic [31:0] addr_i,
  // flags and captured address
  output logic addr_flag_o,
  output logic data_flag_o,
  output logic [31:0] cap_o
);
  logic addr_flag_reg, addr_flag_next;
  logic data_flag_reg, data_flag_next;
  logic [31:0] cap_reg, cap_next;

  always_comb begin
    // a new error in the clear cycle survives the write-one
    addr_flag_next = addr_err_i || (addr_flag_reg && !addr_clr_i);
    data_flag_next = data_err_i || (data_flag_reg && !data_clr_i);
    if (fb_rst_i) begin
      addr_flag_next = 1'b0;
      data_flag_next = 1'b0;
    end
    cap_next = cap_reg;
    // keeps loading until the flag is up, so the failing address stays
    if (addr_valid_i && !addr_flag_reg) begin
      cap_next = addr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      addr_flag_reg <= 1'b0;
      data_flag_reg <= 1'b0;
    end else begin
      addr_flag_reg <= addr_flag_next;
      data_flag_reg <= data_flag_next;
    end
    // capture is never reset; its content is only meaningful with the flag
    cap_reg <= cap_next;
  end

  assign addr_flag_o = addr_flag_reg;
  assign data_flag_o = data_flag_reg;
  assign cap_o = cap_reg;
endmodule
`default_nettype wire

// ===== src/vec_queue.sv
`timescale 1ns/1ps
`default_nettype none
module vec_queue #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // queue ports
  vec_queue_if.owner q
);
  import diag_regs_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  vec_t mem_reg [DEPTH];
  vec_t mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic do_push, do_pop;

  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    // full queue holds the sender off instead of dropping
    do_push = q.push_valid && ready_reg;
    // a pop on an empty queue changes nothing
    do_pop = q.pop && (cnt_reg != '0);
    if (do_push) begin
      mem_next[wr_reg] = q.push_data;
      wr_next = (wr_reg == LAST_PTR) ? '0 : wr_reg + 1'b1;
    end
    if (do_pop) begin
      rd_next = (rd_reg == LAST_PTR) ? '0 : rd_reg + 1'b1;
    end
    if (do_push && !do_pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (do_pop && !do_push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    if (q.flush) begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end
    ready_next = (cnt_next != FULL_CNT);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
    mem_reg <= mem_next;
  end

  assign q.push_ready = ready_reg;
  assign q.empty = (cnt_reg == '0);
  assign q.head = (cnt_reg == '0) ? '0 : mem_reg[rd_reg];
endmodule
`default_nettype wire

// ===== src/vec_queue_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vec_queue_if;
  logic flush;
  logic push_valid;
  logic push_ready;
  diag_regs_pkg::vec_t push_data;
  logic pop;
  logic empty;
  diag_regs_pkg::vec_t head;
  modport owner(input flush, push_valid, push_data, pop, output push_ready, empty, head);
  modport user(output flush, push_valid, push_data, pop, input push_ready, empty, head);
endinterface
`default_nettype wire

// ===== tb/bus_adapter_diag_vector_error_regs_tb_top.sv
`include "diag_regs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module bus_adapter_diag_vector_error_regs_tb_top;
  import diag_regs_pkg::*;
  logic clk_i, srst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o, ivec_valid_i;
  logic ivec_ready_o, halt_wr_i, halt_slot_free_o, conn_phase_i, slave_wr_i, mbox_rd_i;
  logic addr_valid_i, line_fill_i, wbuf_fill_i, dma_block_o, hw_err_irq_o;
  logic [7:0] haddr_i, wa, da;
  logic [1:0] htrans_i, addr_perr_i, data_perr_i, diag_mode_o, fill_idx_i, e;
  logic [2:0] hsize_i;
  logic [31:0] hwdata_i, hrdata_o, d, sc;
  logic [63:0] fb_addr_i, fill_data_i, f, g;
  vec_t ivec_data_i, halt_data_i, v;
  vec_t q[$];
  int num_errors, checked, seed, s, k;
  bit ok;
  assign hready_i = hreadyout_o;
  diag_vector_regs #(.QUEUE_DEPTH(4)) u_diag_vector_regs (
    .clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .ivec_valid_i(ivec_valid_i), .ivec_data_i(ivec_data_i), .ivec_ready_o(ivec_ready_o),
    .halt_wr_i(halt_wr_i), .halt_data_i(halt_data_i), .halt_slot_free_o(halt_slot_free_o),
    .conn_phase_i(conn_phase_i), .slave_wr_i(slave_wr_i), .mbox_rd_i(mbox_rd_i),
    .addr_perr_i(addr_perr_i), .data_perr_i(data_perr_i), .addr_valid_i(addr_valid_i),
    .fb_addr_i(fb_addr_i), .line_fill_i(line_fill_i), .wbuf_fill_i(wbuf_fill_i),
    .fill_idx_i(fill_idx_i), .fill_data_i(fill_data_i), .diag_mode_o(diag_mode_o),
    .dma_block_o(dma_block_o), .hw_err_irq_o(hw_err_irq_o));
  remote_side_model u_remote_side_model (.clk_i(clk_i), .ivec_ready_i(ivec_ready_o),
    .ivec_valid_o(ivec_valid_i), .ivec_data_o(ivec_data_i), .halt_wr_o(halt_wr_i),
    .halt_data_o(halt_data_i));
  task automatic results;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] x, input logic [31:0] a);
    checked++;
    if (a !== x) begin
      num_errors++;
      $display("unexpected at %0t exp %h got %h", $time, x, a);
    end
  endtask
  // one single transfer; read data lands in d
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1 && ++n < 20);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1 && ++n < 20);
    d = hrdata_o;
    if (n >= 20) num_errors++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    cmp(x, d);
    cmp(32'h0, {31'h0, hresp_o});
  endtask
  task automatic perr(input int kind, input logic [1:0] m, input logic [63:0] a);
    conn_phase_i <= kind == 0;
    slave_wr_i <= kind == 1;
    mbox_rd_i <= kind == 2;
    addr_perr_i <= (kind == 0 || kind == 3) ? m : 2'h0;
    data_perr_i <= (kind == 1 || kind == 2) ? m : 2'h0;
    fb_addr_i <= a;
    @(posedge clk_i);
    conn_phase_i <= 1'b0;
    slave_wr_i <= 1'b0;
    mbox_rd_i <= 1'b0;
    addr_perr_i <= 2'h0;
    data_perr_i <= 2'h0;
    fb_addr_i <= ~a;
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    num_errors++;
    results();
  end
  initial begin
    seed = 32'h125E;
    {srst_i, hsel_i, hwrite_i, conn_phase_i, slave_wr_i, mbox_rd_i} = 6'h20;
    {line_fill_i, wbuf_fill_i, addr_perr_i, data_perr_i, fill_idx_i, htrans_i} = 10'h0;
    {haddr_i, hwdata_i, fb_addr_i, fill_data_i} = '0;
    addr_valid_i = 1'b1;
    hsize_i = `HSIZE_WORD;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    for (s = 0; s < 8; s++) rdc(8'(4 * s), 32'h0);
    for (s = 0; s < 2; s++) begin
      da = s ? 8'h04 : 8'h00;
      wa = s ? 8'h60 : 8'h40;
      f = {$random(seed), $random(seed)};
      g = {$random(seed), $random(seed)};
      fill_idx_i <= 2'h0;
      fill_data_i <= f;
      wbuf_fill_i <= 1'b1;
      @(posedge clk_i);
      wbuf_fill_i <= 1'b0;
      line_fill_i <= 1'b1;
      fill_data_i <= g;
      @(posedge clk_i);
      line_fill_i <= 1'b0;
      sc = $random(seed) & 32'h0000FFFC;
      wr(da, sc | 32'h1);
      @(posedge clk_i);
      cmp(32'(1 << s), {30'h0, diag_mode_o});
      cmp(32'h1, {31'h0, dma_block_o});
      rdc(da, sc | 32'h1);
      rdc(wa, g[32 * s +: 32]);
      wr(wa + 8'h4, f[31:0] ^ g[63:32]);
      rdc(wa + 8'h4, f[31:0] ^ g[63:32]);
      wr(da, sc | 32'h3);
      rdc(wa, f[32 * s +: 32]);
      wr(da, 32'h2);
      rdc(wa + 8'h4, 32'h0);
      cmp(32'h0, {31'h0, dma_block_o});
    end
    for (k = 0; k < 5; k++) begin
      v = 16'($random(seed));
      u_remote_side_model.send_ivec(v, ok);
      cmp(32'(k < 4), {31'h0, ok});
      if (ok) q.push_back(v);
    end
    while (q.size() > 0) rdc(`REG_IVEC_LO, {16'h0, q.pop_front()});
    rdc(`REG_IVEC_LO, 32'h0);
    v = 16'($random(seed));
    u_remote_side_model.send_halt(v);
    u_remote_side_model.send_halt(~v);
    cmp(32'h0, {31'h0, halt_slot_free_o});
    rdc(`REG_HALT_LO, {16'h0, v});
    cmp(32'h1, {31'h0, halt_slot_free_o});
    rdc(`REG_HALT_LO, 32'h0);
    u_remote_side_model.send_ivec(v, ok);
    u_remote_side_model.send_halt(v);
    wr(`REG_IOCTL_LO, 32'h80);
    wr(`REG_IOCTL_HI, 32'h80);
    wr(`REG_IOCTL_LO, 32'h0);
    wr(`REG_IOCTL_HI, 32'h0);
    rdc(`REG_IVEC_LO, 32'h0);
    rdc(`REG_HALT_LO, 32'h0);
    // kind 3 is an address fault outside the connection phase: must not count
    for (k = 0; k < 4; k++) begin
      for (s = 1; s < 4; s++) begin
        f = {$random(seed), $random(seed)};
        perr(k, 2'(s), f);
        e = (k == 3) ? 2'h0 : 2'(s);
        sc = (k == 0) ? 32'h2 : 32'h1;
        cmp(32'(e != 2'h0), {31'h0, hw_err_irq_o});
        rdc(`REG_PERR_LO, e[0] ? sc : 32'h0);
        rdc(`REG_PERR_HI, e[1] ? sc : 32'h0);
        if (k == 0 && e[0]) rdc(`REG_CAP_LO, f[31:0]);
        if (k == 0 && e[1]) rdc(`REG_CAP_HI, f[63:32]);
        wr(`REG_PERR_LO, 32'h3);
        wr(`REG_PERR_HI, 32'h3);
        rdc(`REG_PERR_LO, 32'h0);
        cmp(32'h0, {31'h0, hw_err_irq_o});
        if (k == 0 && e[0]) rdc(`REG_CAP_LO, ~f[31:0]);
      end
    end
    perr(1, 2'h3, f);
    wr(`REG_IOCTL_LO, 32'h80);
    wr(`REG_IOCTL_HI, 32'h80);
    wr(`REG_IOCTL_LO, 32'h0);
    wr(`REG_IOCTL_HI, 32'h0);
    rdc(`REG_PERR_HI, 32'h0);
    results();
  end
endmodule
`default_nettype wire

// ===== tb/diag_vector_regs_chk.sv
`include "diag_regs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module diag_vector_regs_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register bus
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic [31:0] hrdata_o,
  // remote side
  input wire logic halt_wr_i,
  input wire logic halt_slot_free_o,
  input wire logic conn_phase_i,
  input wire logic slave_wr_i,
  input wire logic mbox_rd_i,
  input wire logic [1:0] addr_perr_i,
  input wire logic [1:0] data_perr_i,
  // status
  input wire logic [1:0] diag_mode_o,
  input wire logic dma_block_o,
  input wire logic hw_err_irq_o
);
  logic take;
  logic perr_ev;
  assign take = hsel_i && htrans_i[1] && hready_i && hsize_i == `HSIZE_WORD;
  assign perr_ev = (conn_phase_i && addr_perr_i != 2'h0)
    || ((slave_wr_i || mbox_rd_i) && data_perr_i != 2'h0);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_read_one_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (take && hwrite_i |=> hreadyout_o)
    else $error("write stalled");
  // read data may only move at the edge that ends a read
  a_rdata_hold: assert property ($past(hreadyout_o) |-> $stable(hrdata_o))
    else $error("read data moved outside a read");
  a_dma_block_mode: assert property (dma_block_o == (diag_mode_o != 2'h0))
    else $error("dma block does not follow mode");
  a_halt_slot_take: assert property (halt_wr_i && halt_slot_free_o |=> !halt_slot_free_o)
    else $error("halt slot not taken");
  a_halt_slot_cause: assert property ($fell(halt_slot_free_o) |-> $past(halt_wr_i))
    else $error("halt slot filled without a write");
  a_irq_after_perr: assert property (perr_ev |-> ##2 hw_err_irq_o)
    else $error("hardware error interrupt missing");
  a_reset_values: assert property ($fell(srst_i) |-> diag_mode_o == 2'h0
    && halt_slot_free_o && !hw_err_irq_o)
    else $error("bad state after reset");
  c_read: cover property (take && !hwrite_i);
  c_halt: cover property ($fell(halt_slot_free_o));
  c_irq: cover property ($rose(hw_err_irq_o));
endmodule
bind diag_vector_regs diag_vector_regs_chk u_diag_vector_regs_chk (
  .clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .halt_wr_i(halt_wr_i),
  .halt_slot_free_o(halt_slot_free_o), .conn_phase_i(conn_phase_i),
  .slave_wr_i(slave_wr_i), .mbox_rd_i(mbox_rd_i), .addr_perr_i(addr_perr_i),
  .data_perr_i(data_perr_i), .diag_mode_o(diag_mode_o), .dma_block_o(dma_block_o),
  .hw_err_irq_o(hw_err_irq_o));
`default_nettype wire

// ===== tb/remote_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module remote_side_model (
  // clock
  input wire logic clk_i,
  // queue status
  input wire logic ivec_ready_i,
  // vector offers
  output logic ivec_valid_o,
  output diag_regs_pkg::vec_t ivec_data_o,
  output logic halt_wr_o,
  output diag_regs_pkg::vec_t halt_data_o
);
  import diag_regs_pkg::*;
  initial begin
    ivec_valid_o = 1'b0;
    ivec_data_o = 16'hA5A5;
    halt_wr_o = 1'b0;
    halt_data_o = 16'h5A5A;
  end
  // offer held until taken; gives up after a bound so a stuck queue shows
  task automatic send_ivec(input vec_t v, output bit ok);
    int n;
    n = 0;
    ivec_valid_o <= 1'b1;
    ivec_data_o <= v;
    do @(posedge clk_i); while (ivec_ready_i !== 1'b1 && ++n < 40);
    ok = ivec_ready_i;
    ivec_valid_o <= 1'b0;
    ivec_data_o <= ~v;
    // one idle edge so a following offer never re-raises valid in this step
    @(posedge clk_i);
  endtask
  // released lines show the inverse so stale data cannot pass
  task automatic send_halt(input vec_t v);
    halt_wr_o <= 1'b1;
    halt_data_o <= v;
    @(posedge clk_i);
    halt_wr_o <= 1'b0;
    halt_data_o <= ~v;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire
